// [shared/csht_regs.vh]
// Register offsets, field positions, reset values and timing constants for the short/termination block
`ifndef CSHT_REGS_VH
`define CSHT_REGS_VH
`define CSHT_ADDR_SHORT_SETUP 8'h10
`define CSHT_ADDR_TERM_SETUP 8'h11
`define CSHT_ADDR_FAULT 8'h0d
`define CSHT_RST_SHORT_SETUP 8'h84
`define CSHT_RST_TERM_SETUP 8'h40
`define CSHT_SHORT_MASK 8'he7
`define CSHT_TMO_HI 7
`define CSHT_TMO_LO 5
`define CSHT_VSEL_HI 2
`define CSHT_VSEL_LO 0
`define CSHT_TERM_HI 7
`define CSHT_TERM_LO 5
`define CSHT_DIV20_BIT 4
`define CSHT_DIV10_BIT 3
`define CSHT_DIV5_BIT 2
`define CSHT_SYSEN_HI 1
`define CSHT_SYSEN_LO 0
`define CSHT_FLT_SHORT_BIT 3
`define CSHT_SYSEN_LDO 2'h0
`define CSHT_SYSEN_BATNODE 2'h1
`define CSHT_SYSEN_WEAKISO 2'h2
`define CSHT_SYSEN_LDOWEAK 2'h3
// Currents in units of 0.5 mA; 12.5 mA and 170 mA limits
`define CSHT_TERM_MIN 9'h019
`define CSHT_TERM_MAX 9'h154
`define CSHT_CLK_HZ 50000000
`define CSHT_SEC_W 8
`define CSHT_RST_VSEL 3'h4
// Short threshold base, 2.0 V in tenths of a volt
`define CSHT_THR_BASE 8'h14
// Timeout table in seconds
`define CSHT_TMO_0 8'h01
`define CSHT_TMO_1 8'h02
`define CSHT_TMO_2 8'h04
`define CSHT_TMO_3 8'h0a
`define CSHT_TMO_4 8'h1e
`define CSHT_TMO_5 8'h3c
`define CSHT_TMO_6 8'h78
`define CSHT_TMO_7 8'hb4
// Fixed termination table in half-mA units
`define CSHT_FIX_0 9'h019
`define CSHT_FIX_1 9'h041
`define CSHT_FIX_2 9'h069
`define CSHT_FIX_3 9'h091
`define CSHT_FIX_4 9'h0b9
`define CSHT_FIX_5 9'h0eb
`define CSHT_FIX_6 9'h11d
`define CSHT_FIX_7 9'h154
// Ratio multipliers on (code + 1), giving half-mA directly
`define CSHT_MUL_DIV20 10'h005
`define CSHT_MUL_DIV10 10'h00a
`define CSHT_MUL_DIV5 10'h014
`endif

// [rtl/csht_cfg.v]
// Battery-short setup, termination current select and system enable mode logic
`timescale 1ns/1ps
`include "csht_regs.vh"

// Units: voltages in 0.1 V, currents in 0.5 mA steps.
// Fast-charge current is taken as (code + 1) x 50 mA; ratio results
// are exact in half-mA units, so no divider is needed.
// Short timeout has one-second granularity and may end up to
// one second early, as the divider runs free.
// Fault register holds only the short flag; other bits read zero.
// A write of one and a new short in the same cycle keep the flag set.
module csht_cfg #(
  parameter CLK_PER_SEC = `CSHT_CLK_HZ
)
(
  input wire mclk,
  input wire rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_ff,
  input wire [4:0] fast_charge_current_code,
  input wire battery_monitor_en,
  input wire input_supply_present,
  input wire input_power_cycled,
  input wire ldo_active,
  input wire sys_voltage_ok,
  input wire battery_node_ok,
  input wire charge_enabled,
  input wire bat_above_weak,
  input wire [7:0] bat_voltage_dv,
  output reg system_enable_pin_ff,
  output reg iso_switch_dis_ff,
  output reg battery_short_flag_ff,
  output reg [8:0] term_current_ff,
  output reg [2:0] short_volt_sel_ff
);

  // Setup registers
  reg [7:0] short_setup_ff;
  reg [7:0] term_setup_ff;
  // Seconds divider and short timer
  reg [31:0] tick_cnt_ff;
  reg [31:0] tick_last;
  reg sec_tick_ff;
  reg [`CSHT_SEC_W-1:0] sec_cnt_ff;
  reg [`CSHT_SEC_W-1:0] tmo_secs;
  reg [7:0] thr_dv;
  reg below_thr;
  reg [2:0] tmo_code;
  reg short_expired;
  // Termination current path, half-mA units
  reg [8:0] fixed_cur;
  reg [9:0] fast_units;
  reg [9:0] ratio_cur;
  reg ratio_active;
  reg [8:0] nxt_term;
  // System enable path
  reg nxt_sysen;
  reg nxt_iso;
  reg [1:0] sysen_mode;
  reg weak_iso_allowed;
  // Decoded strobes
  reg wr_short;
  reg wr_term;
  reg wr_fault;
  reg flag_clear_req;

  // Timeout code to seconds
  always @*
  begin
    tmo_code = short_setup_ff[`CSHT_TMO_HI:`CSHT_TMO_LO];
    case (tmo_code)
      3'h0: tmo_secs = `CSHT_TMO_0;
      3'h1: tmo_secs = `CSHT_TMO_1;
      3'h2: tmo_secs = `CSHT_TMO_2;
      3'h3: tmo_secs = `CSHT_TMO_3;
      3'h4: tmo_secs = `CSHT_TMO_4;
      3'h5: tmo_secs = `CSHT_TMO_5;
      3'h6: tmo_secs = `CSHT_TMO_6;
      default: tmo_secs = `CSHT_TMO_7;
    endcase
  end

  // Threshold in tenths of a volt, 2.0 V plus code steps
  always @*
  begin
    thr_dv = `CSHT_THR_BASE + {5'h00, short_setup_ff[`CSHT_VSEL_HI:`CSHT_VSEL_LO]};
    below_thr = (bat_voltage_dv < thr_dv);
  end

  // Fixed termination table, half-milliamp units
  always @*
  begin
    case (term_setup_ff[`CSHT_TERM_HI:`CSHT_TERM_LO])
      3'h0: fixed_cur = `CSHT_FIX_0;
      3'h1: fixed_cur = `CSHT_FIX_1;
      3'h2: fixed_cur = `CSHT_FIX_2;
      3'h3: fixed_cur = `CSHT_FIX_3;
      3'h4: fixed_cur = `CSHT_FIX_4;
      3'h5: fixed_cur = `CSHT_FIX_5;
      3'h6: fixed_cur = `CSHT_FIX_6;
      default: fixed_cur = `CSHT_FIX_7;
    endcase
  end

  // Fast-charge steps as (code + 1); a full 50 mA-scaled value would not fit 9 bits
  always @*
  begin
    fast_units = {5'h00, fast_charge_current_code} + 10'h001;
  end

  // Ratio select with fixed priority; products stay exact in half-mA units
  always @*
  begin
    ratio_active = term_setup_ff[`CSHT_DIV20_BIT] | term_setup_ff[`CSHT_DIV10_BIT] |
                   term_setup_ff[`CSHT_DIV5_BIT];
    if (term_setup_ff[`CSHT_DIV20_BIT])
      ratio_cur = fast_units * `CSHT_MUL_DIV20;
    else if (term_setup_ff[`CSHT_DIV10_BIT])
      ratio_cur = fast_units * `CSHT_MUL_DIV10;
    else
      ratio_cur = fast_units * `CSHT_MUL_DIV5;
  end

  // Clamp applies to ratio modes only; the fixed table is already in range
  always @*
  begin
    if (!ratio_active)
      nxt_term = fixed_cur;
    else if (ratio_cur < {1'b0, `CSHT_TERM_MIN})
      nxt_term = `CSHT_TERM_MIN;
    else if (ratio_cur > {1'b0, `CSHT_TERM_MAX})
      nxt_term = `CSHT_TERM_MAX;
    else
      nxt_term = ratio_cur[8:0];
  end

  // Mode 10 is only honoured on battery with the monitor running
  always @*
  begin
    weak_iso_allowed = !input_supply_present && battery_monitor_en;
  end

  // System enable per mode; mode 10 falls back to mode 00 when not allowed
  always @*
  begin
    sysen_mode = term_setup_ff[`CSHT_SYSEN_HI:`CSHT_SYSEN_LO];
    nxt_iso = 1'b0;
    nxt_sysen = 1'b0;
    case (sysen_mode)
      `CSHT_SYSEN_LDO:
      begin
        nxt_sysen = ldo_active & sys_voltage_ok;
      end
      `CSHT_SYSEN_BATNODE:
      begin
        nxt_sysen = battery_node_ok;
      end
      `CSHT_SYSEN_WEAKISO:
      begin
        if (weak_iso_allowed)
        begin
          nxt_sysen = !bat_above_weak;
          nxt_iso = !bat_above_weak;
        end
        else
          nxt_sysen = ldo_active & sys_voltage_ok;
      end
      default:
        nxt_sysen = charge_enabled ? bat_above_weak : ldo_active;
    endcase
  end

  // Write strobes decoded once, shared by the register and flag logic
  always @*
  begin
    wr_short = reg_wr && (reg_addr == `CSHT_ADDR_SHORT_SETUP);
    wr_term = reg_wr && (reg_addr == `CSHT_ADDR_TERM_SETUP);
    wr_fault = reg_wr && (reg_addr == `CSHT_ADDR_FAULT);
  end

  // Setup registers; unused short bits are masked at the write
  always @(posedge mclk)
  begin
    if (rst)
    begin
      short_setup_ff <= `CSHT_RST_SHORT_SETUP;
      term_setup_ff <= `CSHT_RST_TERM_SETUP;
    end
    else
    begin
      if (wr_short)
        short_setup_ff <= reg_wdata & `CSHT_SHORT_MASK;
      if (wr_term)
        term_setup_ff <= reg_wdata;
    end
  end

  // Last count of the seconds divider
  always @*
  begin
    tick_last = CLK_PER_SEC - 1;
  end

  // Seconds enable from a divider; a one-cycle pulse keeps a single clock
  always @(posedge mclk)
  begin
    if (rst)
    begin
      tick_cnt_ff <= 32'h0000_0000;
      sec_tick_ff <= 1'b0;
    end
    else if (tick_cnt_ff == tick_last)
    begin
      tick_cnt_ff <= 32'h0000_0000;
      sec_tick_ff <= 1'b1;
    end
    else
    begin
      tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
      sec_tick_ff <= 1'b0;
    end
  end

  // Expiry and clear requests
  always @*
  begin
    short_expired = (sec_cnt_ff == tmo_secs);
    flag_clear_req = input_power_cycled | (wr_fault & reg_wdata[`CSHT_FLT_SHORT_BIT]);
  end

  // Short timer; any recovery restarts it, so brief dips never add up
  always @(posedge mclk)
  begin
    if (rst)
      sec_cnt_ff <= {`CSHT_SEC_W{1'b0}};
    else if (!below_thr)
      sec_cnt_ff <= {`CSHT_SEC_W{1'b0}};
    else if (sec_tick_ff && !short_expired)
      sec_cnt_ff <= sec_cnt_ff + 8'h01;
  end

  // Sticky short flag; a new short in the clearing cycle wins
  always @(posedge mclk)
  begin
    if (rst)
      battery_short_flag_ff <= 1'b0;
    else if (below_thr && short_expired)
      battery_short_flag_ff <= 1'b1;
    else if (flag_clear_req)
      battery_short_flag_ff <= 1'b0;
  end

  // Registered pin and status outputs
  always @(posedge mclk)
  begin
    if (rst)
    begin
      system_enable_pin_ff <= 1'b0;
      iso_switch_dis_ff <= 1'b0;
      term_current_ff <= `CSHT_TERM_MIN;
      short_volt_sel_ff <= `CSHT_RST_VSEL;
    end
    else
    begin
      system_enable_pin_ff <= nxt_sysen;
      iso_switch_dis_ff <= nxt_iso;
      term_current_ff <= nxt_term;
      short_volt_sel_ff <= short_setup_ff[`CSHT_VSEL_HI:`CSHT_VSEL_LO];
    end
  end

  // Read data stands one cycle; unmapped addresses read zero
  always @(posedge mclk)
  begin
    if (rst)
      reg_rdata_ff <= 8'h00;
    else if (reg_rd && reg_addr == `CSHT_ADDR_SHORT_SETUP)
      reg_rdata_ff <= short_setup_ff;
    else if (reg_rd && reg_addr == `CSHT_ADDR_TERM_SETUP)
      reg_rdata_ff <= term_setup_ff;
    else if (reg_rd && reg_addr == `CSHT_ADDR_FAULT)
      reg_rdata_ff <= {4'h0, battery_short_flag_ff, 3'h0};
    else
      reg_rdata_ff <= 8'h00;
  end

endmodule // csht_cfg

// [test/csht_host.sv]
// Host model issuing register accesses
`timescale 1ns/1ps
module csht_host(
  input wire mclk,
  output reg reg_wr = 1'b0,
  output reg reg_rd = 1'b0,
  output reg [7:0] reg_addr = 8'h00,
  output reg [7:0] reg_wdata = 8'h00,
  input wire [7:0] reg_rdata_ff
);
  // Released lines inverted so stale values never match
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge mclk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
      @(posedge mclk) {reg_wr, reg_addr, reg_wdata} <= {1'b0, ~a, ~v};
    end
  endtask
  // Read data stands one cycle only
  task rd(input [7:0] a, output [7:0] v);
    begin
      @(posedge mclk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge mclk) {reg_rd, reg_addr} <= {1'b0, ~a};
      #1 v = reg_rdata_ff;
    end
  endtask
endmodule // csht_host

// [test/csht_cfg_properties.sv]
// Checker bound to the short/termination config block
`timescale 1ns/1ps
module csht_chk(
  input wire mclk, rst, reg_wr, reg_rd, input_power_cycled, battery_short_flag_ff,
  input wire [7:0] reg_addr, reg_wdata, reg_rdata_ff, bat_voltage_dv,
  input wire [4:0] fast_charge_current_code,
  input wire [8:0] term_current_ff,
  input wire [2:0] short_volt_sel_ff
);
  // Decoded strobes; fast charge taken as (code+1)*50 mA
  wire [9:0] fc = {5'h00, fast_charge_current_code} + 10'h001;
  wire w10 = reg_wr && reg_addr == 8'h10;
  wire w11 = reg_wr && reg_addr == 8'h11;
  wire clr = input_power_cycled || (reg_wr && reg_addr == 8'h0d && reg_wdata[3]);
  // Clamp in half-mA units
  function [8:0] lim(input [9:0] v);
    lim = v < 10'h019 ? 9'h019 : (v > 10'h154 ? 9'h154 : v[8:0]);
  endfunction
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Lone write, then a quiet cycle for the output to follow
  sequence one_wr(w, c);
    w && c ##1 !w;
  endsequence
  rst_vsel_a: assert property (
    $fell(rst) |-> short_volt_sel_ff == 3'h4) else $error("bad threshold reset");
  unused_bits_a: assert property (
    reg_rd && reg_addr == 8'h10 |=> reg_rdata_ff[4:3] == 2'h0) else $error("unused bits set");
  volt_sel_a: assert property (
    one_wr(w10, 1'b1) |=> short_volt_sel_ff == $past(reg_wdata[2:0], 2))
    else $error("threshold not applied");
  div20_term_a: assert property (
    one_wr(w11, reg_wdata[4]) |=> term_current_ff == lim(fc * 10'h005)) else $error("bad div20");
  div10_term_a: assert property (
    one_wr(w11, reg_wdata[4:3] == 2'h1) |=> term_current_ff == lim(fc * 10'h00a))
    else $error("bad div10");
  div5_term_a: assert property (
    one_wr(w11, reg_wdata[4:2] == 3'h1) |=> term_current_ff == lim(fc * 10'h014))
    else $error("bad div5");
  flag_clear_a: assert property (
    clr && bat_voltage_dv > 8'h1b |=> !battery_short_flag_ff) else $error("flag not cleared");
  flag_hold_a: assert property (
    battery_short_flag_ff && !clr |=> battery_short_flag_ff) else $error("flag dropped");
endmodule // csht_chk
bind csht_cfg csht_chk u_chk(.*);

// [test/csht_cfg_bench.sv]
// Self-checking bench for the short/termination config block
`timescale 1ns/1ps
module csht_cfg_bench;
  reg mclk = 1'b0, rst = 1'b1, input_power_cycled = 1'b0, charge_enabled = 1'b1;
  reg battery_monitor_en = 1'b1, input_supply_present = 1'b0, ldo_active = 1'b1;
  reg sys_voltage_ok = 1'b1, battery_node_ok = 1'b1, bat_above_weak = 1'b0;
  reg [4:0] fast_charge_current_code = 5'h00;
  reg [7:0] bat_voltage_dv = 8'h1e, d;
  wire reg_wr, reg_rd, system_enable_pin_ff, iso_switch_dis_ff, battery_short_flag_ff;
  wire [7:0] reg_addr, reg_wdata, reg_rdata_ff;
  wire [8:0] term_current_ff;
  wire [2:0] short_volt_sel_ff;
  integer n_mismatch = 0, n_tests = 0, i;
  // 50 MHz clock
  initial forever #10 mclk = ~mclk;
  csht_host u_host(.*);
  // One second shortened to ten clocks
  csht_cfg #(.CLK_PER_SEC(10)) u_csht_cfg(.*);
  task chk(input [8:0] s, input [8:0] e);
    begin
      n_tests = n_tests + 1;
      if (s !== e)
      begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  task wt(input integer n);
    begin repeat (n) @(posedge mclk); #1; end
  endtask
  task rdc(input [7:0] a, input [8:0] e);
    begin u_host.rd(a, d); chk({1'b0, d}, e); end
  endtask
  task tchk(input [4:0] f, input [7:0] v, input [8:0] e);
    begin
      @(posedge mclk) fast_charge_current_code <= f;
      u_host.wr(8'h11, v);
      wt(2);
      chk(term_current_ff, e);
    end
  endtask
  task report_and_stop;
    begin
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // Watchdog, far past the roughly 160 cycles needed
  initial
  begin
    repeat (3000) @(posedge mclk);
    n_mismatch = n_mismatch + 1;
    report_and_stop;
  end
  // Main sequence
  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    wt(2);
    chk(term_current_ff, 9'h069);
    chk(short_volt_sel_ff, 9'h004);
    rdc(8'h10, 9'h084);
    rdc(8'h11, 9'h040);
    u_host.wr(8'h10, 8'hff);
    rdc(8'h10, 9'h0e7);
    $display("reset test done");
    tchk(5'h00, 8'h10, 9'h019);
    tchk(5'h1f, 8'h04, 9'h154);
    tchk(5'h09, 8'h08, 9'h064);
    tchk(5'h09, 8'h1c, 9'h032);
    tchk(5'h09, 8'he0, 9'h154);
    $display("termination test done");
    for (i = 0; i < 4; i = i + 1)
    begin
      u_host.wr(8'h11, i[7:0]);
      wt(2);
      chk(system_enable_pin_ff, i != 3);
      chk(iso_switch_dis_ff, i == 2);
    end
    bat_above_weak <= 1'b1;
    wt(2);
    chk(system_enable_pin_ff, 9'h001);
    u_host.wr(8'h11, 8'h02);
    input_supply_present <= 1'b1;
    wt(2);
    chk(iso_switch_dis_ff, 9'h000);
    chk(system_enable_pin_ff, 9'h001);
    input_supply_present <= 1'b0;
    $display("enable test done");
    u_host.wr(8'h10, 8'h02);
    bat_voltage_dv <= 8'h16;
    wt(40);
    chk(battery_short_flag_ff, 9'h000);
    chk(short_volt_sel_ff, 9'h002);
    bat_voltage_dv <= 8'h15;
    wt(25);
    rdc(8'h0d, 9'h008);
    bat_voltage_dv <= 8'h1e;
    u_host.wr(8'h0d, 8'h08);
    wt(1);
    chk(battery_short_flag_ff, 9'h000);
    bat_voltage_dv <= 8'h15;
    wt(25);
    chk(battery_short_flag_ff, 9'h001);
    bat_voltage_dv <= 8'h1e;
    input_power_cycled <= 1'b1;
    wt(1);
    input_power_cycled <= 1'b0;
    chk(battery_short_flag_ff, 9'h000);
    $display("short test done");
    report_and_stop;
  end
endmodule // csht_cfg_bench
